//--- core/tmi_defines.svh
// Register offsets, field positions and thresholds of the thermal monitor
`ifndef TMI_DEFINES_SVH
`define TMI_DEFINES_SVH
// Register offsets
`define TMI_OFS_TOP      8'h00
`define TMI_OFS_CFG      8'h01
`define TMI_OFS_TSTAT    8'h02
`define TMI_OFS_FLAG     8'h10
`define TMI_OFS_MASK     8'h20
`define TMI_NGRP         9
// Flag group indices
`define TMI_G_REGA       0
`define TMI_G_REGB       1
`define TMI_G_SEV        2
`define TMI_G_MOD        3
`define TMI_G_MISC       4
`define TMI_G_START      5
`define TMI_G_GRISE      6
`define TMI_G_GFALL      7
`define TMI_G_GHI        8
// Field positions
`define TMI_CFG_LEVEL    0
`define TMI_CFG_LPM      1
`define TMI_TS_ORDREC    0
`define TMI_TS_IMMREC    1
`define TMI_MISC_WARN    2
`define TMI_SEV_IMM      0
`define TMI_MOD_ORD      5
// Reset values
`define TMI_CFG_RST      8'h00
`define TMI_MASK_RST     8'h00
// Thresholds in degrees Celsius
`define TMI_TWARN_LO     8'h82
`define TMI_TWARN_HI     8'h8c
`define TMI_TSD_ORD      8'h96
`define TMI_TSD_IMM      8'ha0
`endif

//--- core/tmi_pkg.sv
// Types shared by the thermal monitor and interrupt tree
package tmi_pkg;
	typedef logic [7:0] tmi_byte_t;
	typedef enum logic [1:0] {
		SD_IDLE,
		SD_ORDERLY,
		SD_IMMEDIATE,
		SD_RECOVERY
	} tmi_sd_e;
endpackage : tmi_pkg

//--- core/tmi_thermal_irq.sv
// Thermal supervision and hierarchical interrupt aggregator
// What this block does
// - Supervise temperature only with rails on in mission
// - Low-power mode polls one detector below warning
// - Warning flag above 130 or 140, no hysteresis
// - Orderly and immediate shutdown flags, error triggers
// - Orderly turn-off, escalate to immediate with pull-down
// - Thermal shutdown recorded in a status register
// - No restart until below warning threshold
// - Severe errors: immediate turn-off, then safe recovery
// - Moderate errors: orderly turn-off, then safe recovery
// - Regulator group: OV, UV, short, overcurrent flags
// - Misc group: watchdog, monitor, warning, selftest, sync
// - Start-up group records power-up cause
// - GPIO rise and fall flags per pin
// - All unmasked pending flags OR onto low interrupt pin
// - Summary register names pending categories
// - Writing one clears a flag, zero keeps it
// - Flags stay latched until the host clears them
// - Masked events neither set flags nor the pin
// - Masking later keeps an existing flag
// - Selected flags and driver enable for SPI status
//
// Chosen here: the placing of the registers and the strobed register port.
`include "tmi_defines.svh"
module tmi_thermal_irq (
	// Clock, reset, enable
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          ce,
	// Register port
	input  wire logic [7:0]    regAddr,
	input  wire tmi_pkg::tmi_byte_t regWdata,
	input  wire logic          regWr,
	input  wire logic          regRd,
	output tmi_pkg::tmi_byte_t regRdata,
	// Thermal detectors
	input  wire logic [7:0]    dieTempA,
	input  wire logic [7:0]    dieTempB,
	input  wire logic          railOnMission,
	input  wire logic          lowPowerStandby,
	output logic [1:0]         sensorEnable,
	// Regulator fault levels
	input  wire logic [3:0]    regOv,
	input  wire logic [3:0]    regUv,
	input  wire logic [3:0]    regSc,
	input  wire logic [3:0]    regResidual,
	input  wire logic [3:0]    regIlim,
	// Other fault and event sources
	input  wire logic          seqExecErr,
	input  wire logic          supplyOv,
	input  wire logic          recoveryCountErr,
	input  wire logic          serialIfErr,
	input  wire logic          regCrcErr,
	input  wire logic          selfTestFail,
	input  wire logic          readbackErr,
	input  wire logic          watchdogFault,
	input  wire logic          errSignalMonFault,
	input  wire logic          selfTestPass,
	input  wire logic          syncClkAvail,
	input  wire logic          firstSupplyDetect,
	input  wire logic          enablePinActive,
	input  wire logic [9:0]    gpioIn,
	input  wire logic          driverEnableIn,
	// Sequencing handshake
	input  wire logic          turnOffDone,
	input  wire logic          restartReq,
	output logic               orderlyTurnOff,
	output logic               immediateTurnOff,
	output logic               railPullDown,
	output logic               safeRecovery,
	output logic               restartBlocked,
	// Host side
	output logic               interruptOut_n,
	output tmi_pkg::tmi_byte_t spiStatus
);
	import tmi_pkg::*;

	// Group index of a flag or mask address, or NGRP on a miss
	function automatic logic [3:0] grpIdx(input logic [7:0] a,
		input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		grpIdx = (d < 8'(`TMI_NGRP)) ? d[3:0] : 4'(`TMI_NGRP);
	endfunction : grpIdx

	tmi_byte_t  flags_r [0:`TMI_NGRP-1];
	tmi_byte_t  masks_r [0:`TMI_NGRP-1];
	tmi_byte_t  evt     [0:`TMI_NGRP-1];
	tmi_byte_t  cfg_r;
	tmi_sd_e    state_r;
	tmi_sd_e    state_nxt;
	logic [1:0] tsdRec_r;
	logic       warnBHeld_r;
	logic [9:0] gpioPrev_r;
	logic [7:0] warnThr;
	logic [7:0] tempB;
	logic       monOn;
	logic       warnA;
	logic       warnB;
	logic       ordEvt;
	logic       immEvt;
	logic       warnEvt;
	logic       severeTrig;
	logic       moderateTrig;
	logic [9:0] gRise;
	logic [9:0] gFall;
	logic [5:0] topSum;
	logic       pend;
	logic [3:0] wrFlagG;
	logic [3:0] wrMaskG;
	// Warning threshold from the level select
	assign warnThr = cfg_r[`TMI_CFG_LEVEL] ? `TMI_TWARN_HI
		: `TMI_TWARN_LO;
	// Off in standby, on while any rail runs in mission
	assign monOn = railOnMission & ~lowPowerStandby;
	// Detector B seen live only while polled, else read as zero; its warning keeps the last result
	assign tempB = sensorEnable[1] ? dieTempB : 8'h00;
	assign warnA = dieTempA > warnThr;
	assign warnB = sensorEnable[1] ? (dieTempB > warnThr)
		: warnBHeld_r;
	assign warnEvt = monOn & (warnA | warnB);
	assign ordEvt = monOn & ((dieTempA >= `TMI_TSD_ORD)
		| (tempB >= `TMI_TSD_ORD));
	assign immEvt = monOn & ((dieTempA >= `TMI_TSD_IMM)
		| (tempB >= `TMI_TSD_IMM));
	// Triggers act whatever the masks say
	assign severeTrig = immEvt | seqExecErr | supplyOv;
	assign moderateTrig = ordEvt | recoveryCountErr | serialIfErr
		| regCrcErr | selfTestFail | readbackErr;
	// GPIO edges against the previous sample
	assign gRise = gpioIn & ~gpioPrev_r;
	assign gFall = ~gpioIn & gpioPrev_r;
	// Event vectors of each category
	assign evt[`TMI_G_REGA] = {regUv, regOv};
	assign evt[`TMI_G_REGB] = {regIlim, regSc | regResidual};
	assign evt[`TMI_G_SEV] = {5'h00, supplyOv, seqExecErr,
		immEvt};
	assign evt[`TMI_G_MOD] = {2'h0, ordEvt, readbackErr,
		selfTestFail, regCrcErr, serialIfErr,
		recoveryCountErr};
	assign evt[`TMI_G_MISC] = {3'h0, syncClkAvail, selfTestPass,
		warnEvt, errSignalMonFault, watchdogFault};
	assign evt[`TMI_G_START] = {6'h00, enablePinActive,
		firstSupplyDetect};
	assign evt[`TMI_G_GRISE] = gRise[7:0];
	assign evt[`TMI_G_GFALL] = gFall[7:0];
	assign evt[`TMI_G_GHI] = {4'h0, gFall[9:8], gRise[9:8]};
	// Group decode, shared by the write and read paths
	assign wrFlagG = grpIdx(regAddr, `TMI_OFS_FLAG);
	assign wrMaskG = grpIdx(regAddr, `TMI_OFS_MASK);
	// Sticky flags: clear by one, then masked set wins over clear
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int g = 0; g < `TMI_NGRP; g++) begin
				flags_r[g] <= 8'h00;
			end
		end else if (ce) begin
			for (int g = 0; g < `TMI_NGRP; g++) begin
				flags_r[g] <= (flags_r[g]
					& ~((regWr && wrFlagG == 4'(g))
					? regWdata : 8'h00))
					| (evt[g] & ~masks_r[g]);
			end
		end
	end

	// Mask registers, zero means event is recorded
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int g = 0; g < `TMI_NGRP; g++) begin
				masks_r[g] <= `TMI_MASK_RST;
			end
		end else if (ce && regWr && wrMaskG != 4'(`TMI_NGRP)) begin
			masks_r[wrMaskG] <= regWdata;
		end
	end

	// Configuration: warning level and low-power polling
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cfg_r <= `TMI_CFG_RST;
		end else if (ce && regWr && regAddr == `TMI_OFS_CFG) begin
			cfg_r <= {6'h00, regWdata[1:0]};
		end
	end

	// GPIO history for edge detection
	always_ff @(posedge clk) begin
		if (!nrst) begin
			gpioPrev_r <= 10'h000;
		end else if (ce) begin
			gpioPrev_r <= gpioIn;
		end
	end

	// Detector enables; polling one saves current below warning
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sensorEnable <= 2'h0;
			warnBHeld_r <= 1'b0;
		end else if (ce) begin
			warnBHeld_r <= warnB;
			if (!monOn) begin
				sensorEnable <= 2'h0;
			end else if (cfg_r[`TMI_CFG_LPM] && !warnA && !warnB) begin
				sensorEnable <= 2'h1;
			end else begin
				sensorEnable <= 2'h3;
			end
		end
	end

	// Shutdown record, independent of the masks
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tsdRec_r <= 2'h0;
		end else if (ce) begin
			tsdRec_r <= (tsdRec_r & ~((regWr
				&& regAddr == `TMI_OFS_TSTAT) ? regWdata[1:0]
				: 2'h0)) | {immEvt, ordEvt};
		end
	end

	// Restart lock until below warning; a new shutdown wins
	always_ff @(posedge clk) begin
		if (!nrst) begin
			restartBlocked <= 1'b0;
		end else if (ce) begin
			if (ordEvt || immEvt) begin
				restartBlocked <= 1'b1;
			end else if (dieTempA < warnThr && dieTempB < warnThr) begin
				restartBlocked <= 1'b0;
			end
		end
	end

	// Turn-off sequencing; severe escalates an orderly turn-off
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SD_IDLE: begin
				if (severeTrig) begin
					state_nxt = SD_IMMEDIATE;
				end else if (moderateTrig) begin
					state_nxt = SD_ORDERLY;
				end
			end
			SD_ORDERLY: begin
				if (severeTrig) begin
					state_nxt = SD_IMMEDIATE;
				end else if (turnOffDone) begin
					state_nxt = SD_RECOVERY;
				end
			end
			SD_IMMEDIATE: begin
				if (turnOffDone) begin
					state_nxt = SD_RECOVERY;
				end
			end
			SD_RECOVERY: begin
				if (restartReq && !restartBlocked) begin
					state_nxt = SD_IDLE;
				end
			end
			default: begin
				state_nxt = SD_IDLE;
			end
		endcase
	end

	// State register and its decoded outputs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_r <= SD_IDLE;
			orderlyTurnOff <= 1'b0;
			immediateTurnOff <= 1'b0;
			railPullDown <= 1'b0;
			safeRecovery <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			orderlyTurnOff <= state_nxt == SD_ORDERLY;
			immediateTurnOff <= state_nxt == SD_IMMEDIATE;
			railPullDown <= state_nxt == SD_IMMEDIATE;
			safeRecovery <= state_nxt == SD_RECOVERY;
		end
	end

	// Category summary, regulator and GPIO groups merged
	always_comb begin
		topSum[0] = |{flags_r[`TMI_G_REGA], flags_r[`TMI_G_REGB]};
		topSum[1] = |flags_r[`TMI_G_SEV];
		topSum[2] = |flags_r[`TMI_G_MOD];
		topSum[3] = |flags_r[`TMI_G_MISC];
		topSum[4] = |flags_r[`TMI_G_START];
		topSum[5] = |{flags_r[`TMI_G_GRISE], flags_r[`TMI_G_GFALL],
			flags_r[`TMI_G_GHI]};
		pend = 1'b0;
		for (int g = 0; g < `TMI_NGRP; g++) begin
			pend = pend | (|(flags_r[g] & ~masks_r[g]));
		end
	end

	// Pin and SPI status come from flops
	always_ff @(posedge clk) begin
		if (!nrst) begin
			interruptOut_n <= 1'b1;
			spiStatus <= 8'h00;
		end else if (ce) begin
			interruptOut_n <= ~pend;
			spiStatus <= {driverEnableIn, ~interruptOut_n,
				topSum};
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!nrst) begin
			regRdata <= 8'h00;
		end else if (ce) begin
			regRdata <= 8'h00;
			if (regRd) begin
				if (regAddr == `TMI_OFS_TOP) begin
					regRdata <= {2'h0, topSum};
				end else if (regAddr == `TMI_OFS_CFG) begin
					regRdata <= cfg_r;
				end else if (regAddr == `TMI_OFS_TSTAT) begin
					regRdata <= {2'h0, sensorEnable, monOn,
						restartBlocked, tsdRec_r};
				end else if (wrFlagG != 4'(`TMI_NGRP)) begin
					regRdata <= flags_r[wrFlagG];
				end else if (wrMaskG != 4'(`TMI_NGRP)) begin
					regRdata <= masks_r[wrMaskG];
				end
			end
		end
	end

	// Checks
	sequence seqSevereSeen;
		ce && severeTrig && (state_r == SD_IDLE
			|| state_r == SD_ORDERLY);
	endsequence
	sequence seqImmReached;
		state_r == SD_IMMEDIATE && railPullDown;
	endsequence
	chk_pin_asserts: assert property (
		@(posedge clk) disable iff (!nrst)
		ce && pend |=> !interruptOut_n)
		else $error("pin not low with pending flag");
	chk_pin_release: assert property (
		@(posedge clk) disable iff (!nrst)
		ce && !pend |=> interruptOut_n)
		else $error("pin low with nothing pending");
	chk_mask_blocks: assert property (
		@(posedge clk) disable iff (!nrst)
		ce && masks_r[4][0] && !flags_r[4][0] |=> !flags_r[4][0])
		else $error("masked watchdog was recorded");
	chk_flag_holds: assert property (
		@(posedge clk) disable iff (!nrst)
		ce && flags_r[4][2] && !(regWr && wrFlagG == 4'h4
		&& regWdata[2]) |=> flags_r[4][2])
		else $error("flag lost without clear");
	chk_w1c_clears: assert property (
		@(posedge clk) disable iff (!nrst)
		ce && regWr && wrFlagG == 4'h4 && regWdata[2]
		&& !warnEvt |=> !flags_r[4][2])
		else $error("write one did not clear flag");
	chk_severe_imm: assert property (
		@(posedge clk) disable iff (!nrst)
		seqSevereSeen |=> seqImmReached ##0 immediateTurnOff)
		else $error("severe error not immediate");
	chk_warn_flag: assert property (
		@(posedge clk) disable iff (!nrst)
		ce && monOn && dieTempA > warnThr && !masks_r[4][2]
		|=> flags_r[4][2])
		else $error("warning not flagged");
	chk_lpm_poll: assert property (
		@(posedge clk) disable iff (!nrst)
		ce && monOn && cfg_r[1] && !warnA && !warnB
		|=> sensorEnable == 2'h1)
		else $error("low power poll not one detector");
	chk_standby_off: assert property (
		@(posedge clk) disable iff (!nrst)
		ce && lowPowerStandby |=> sensorEnable == 2'h0)
		else $error("monitor on in standby");
	chk_restart_lock: assert property (
		@(posedge clk) disable iff (!nrst)
		ce && state_r == SD_RECOVERY && restartBlocked
		|=> state_r == SD_RECOVERY)
		else $error("restart while blocked");
	chk_moderate_ord: assert property (
		@(posedge clk) disable iff (!nrst)
		ce && state_r == SD_IDLE && moderateTrig && !severeTrig
		|=> orderlyTurnOff [*1])
		else $error("moderate error not orderly");

endmodule : tmi_thermal_irq

//--- tb/tmi_host_model.sv
// Host processor model: register bus master and interrupt service
`include "tmi_defines.svh"
module tmi_host_model (
	// Clock
	input  wire logic         clk,
	// Register port
	output logic [7:0]        regAddr,
	output tmi_pkg::tmi_byte_t regWdata,
	output logic              regWr,
	output logic              regRd,
	input  wire tmi_pkg::tmi_byte_t regRdata
);
	timeunit 1ns;
	timeprecision 1ns;
	import tmi_pkg::*;

	// Bus idle from time zero
	initial begin
		regAddr = 8'h00;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
	end

	// One-cycle write strobe beside address and data
	task wr(input logic [7:0] a, input tmi_byte_t d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr

	// Data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, output tmi_byte_t d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask : rd

	// Summary first, then only the named groups; gap models a slow host
	task service(input int gap);
		tmi_byte_t top;
		tmi_byte_t f;
		int b;
		repeat (gap) @(posedge clk);
		rd(`TMI_OFS_TOP, top);
		for (int g = 0; g < 9; g++) begin
			b = (g < 2) ? 0 : (g > 5) ? 5 : g - 1;
			if (top[b]) begin
				rd(`TMI_OFS_FLAG + g[7:0], f);
				wr(`TMI_OFS_FLAG + g[7:0], f);
			end
		end
	endtask : service
endmodule : tmi_host_model

//--- tb/tmi_thermal_irq_tb.sv
// Self-checking bench for the thermal monitor and interrupt tree
`include "tmi_defines.svh"
module tmi_thermal_irq_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import tmi_pkg::*;
	logic       clk, nrst, ce, regWr, regRd, railOn, standby;
	logic       drvEn, offDone, restart, ordOff, immOff;
	logic       pullDn, safeRec, rstBlk, intOut_n;
	logic [7:0] regAddr, tempA, tempB;
	tmi_byte_t  regWdata, regRdata, spiStatus;
	logic [32:0] src;
	logic [9:0] gpio;
	logic [1:0] sensEn;
	int         n_fail = 0;
	int         tests_run = 0;
	int         cyc = 0;
	// Rows: source index, group, expected flag byte
	logic [19:0] rows [18] = '{20'h00001, 20'h07080, 20'h09102,
		20'h0e104, 20'h13180, 20'h14202, 20'h15204, 20'h16301,
		20'h17302, 20'h18304, 20'h19308, 20'h1a310, 20'h1b401,
		20'h1c402, 20'h1d408, 20'h1e410, 20'h1f501, 20'h20502};

	tmi_host_model host (.clk(clk), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata));

	tmi_thermal_irq uut (
		.clk(clk), .nrst(nrst), .ce(ce),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata),
		.dieTempA(tempA), .dieTempB(tempB), .railOnMission(railOn),
		.lowPowerStandby(standby), .sensorEnable(sensEn),
		.regOv(src[3:0]), .regUv(src[7:4]), .regSc(src[11:8]),
		.regResidual(src[15:12]), .regIlim(src[19:16]),
		.seqExecErr(src[20]), .supplyOv(src[21]),
		.recoveryCountErr(src[22]), .serialIfErr(src[23]),
		.regCrcErr(src[24]), .selfTestFail(src[25]),
		.readbackErr(src[26]), .watchdogFault(src[27]),
		.errSignalMonFault(src[28]), .selfTestPass(src[29]),
		.syncClkAvail(src[30]), .firstSupplyDetect(src[31]),
		.enablePinActive(src[32]), .gpioIn(gpio),
		.driverEnableIn(drvEn), .turnOffDone(offDone),
		.restartReq(restart), .orderlyTurnOff(ordOff),
		.immediateTurnOff(immOff), .railPullDown(pullDn),
		.safeRecovery(safeRec), .restartBlocked(rstBlk),
		.interruptOut_n(intOut_n), .spiStatus(spiStatus));

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	task chk(input tmi_byte_t g, input tmi_byte_t e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk

	task rchk(input logic [7:0] a, input tmi_byte_t e);
		tmi_byte_t d;
		host.rd(a, d);
		chk(d, e);
	endtask : rchk

	// Let n edges land, then step off the edge
	task w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : w

	// One-cycle event, then time for flag and pin to settle
	task pulse(input int i);
		@(posedge clk) src <= 33'h1 << i;
		@(posedge clk) src <= '0;
		w(2);
	endtask : pulse

	// Hang guard well above the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_fail++;
			print_verdict();
		end
	end

	initial begin
		int g;
		nrst = 1'b0;
		ce = 1'b1;
		railOn = 1'b1;
		standby = 1'b0;
		drvEn = 1'b1;
		offDone = 1'b1;
		restart = 1'b1;
		tempA = 8'd25;
		tempB = 8'd25;
		src = '0;
		gpio = '0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rchk(`TMI_OFS_CFG, `TMI_CFG_RST);
		rchk(`TMI_OFS_MASK, `TMI_MASK_RST);
		rchk(`TMI_OFS_TOP, 8'h00);
		rchk(8'h30, 8'h00);
		chk({7'h0, intOut_n}, 8'h01);
		$display("test reset done");
		// 18 of the 33 sources once each; the sequencer always completes here
		foreach (rows[i]) begin
			g = int'(rows[i][11:8]);
			pulse(int'(rows[i][19:12]));
			rchk(`TMI_OFS_FLAG + g[7:0], rows[i][7:0]);
			rchk(`TMI_OFS_TOP, 8'h01 << (g - (g > 0)));
			chk({7'h0, intOut_n}, 8'h00);
			host.wr(`TMI_OFS_FLAG + g[7:0], rows[i][7:0]);
			rchk(`TMI_OFS_FLAG + g[7:0], 8'h00);
			chk({7'h0, intOut_n}, 8'h01);
		end
		$display("test sources done");
		// Second event while the pin is already low
		pulse(0);
		pulse(1);
		host.wr(`TMI_OFS_FLAG, 8'h01);
		host.wr(`TMI_OFS_FLAG, 8'h00);
		rchk(`TMI_OFS_FLAG, 8'h02);
		chk(spiStatus, 8'hc1);
		host.service(5);
		w(2);
		chk({7'h0, intOut_n}, 8'h01);
		$display("test latch done");
		// Masked watchdog event, then mask applied after the event
		host.wr(`TMI_OFS_MASK + 8'h04, 8'h01);
		pulse(27);
		rchk(`TMI_OFS_FLAG + 8'h04, 8'h00);
		chk({7'h0, intOut_n}, 8'h01);
		host.wr(`TMI_OFS_MASK + 8'h04, 8'h00);
		pulse(27);
		host.wr(`TMI_OFS_MASK + 8'h04, 8'h01);
		pulse(27);
		rchk(`TMI_OFS_FLAG + 8'h04, 8'h01);
		chk({7'h0, intOut_n}, 8'h01);
		host.wr(`TMI_OFS_FLAG + 8'h04, 8'h01);
		host.wr(`TMI_OFS_MASK + 8'h04, 8'h00);
		$display("test mask done");
		// Edges on the lowest and highest pins
		@(posedge clk) gpio <= 10'h201;
		w(3);
		@(posedge clk) gpio <= 10'h000;
		w(3);
		rchk(`TMI_OFS_FLAG + 8'h06, 8'h01);
		rchk(`TMI_OFS_FLAG + 8'h07, 8'h01);
		rchk(`TMI_OFS_FLAG + 8'h08, 8'h0a);
		host.service(0);
		$display("test gpio done");
		// Warning edge at both levels; no hysteresis to get past
		@(posedge clk) begin
			offDone <= 1'b0;
			restart <= 1'b0;
			tempA <= 8'd130;
		end
		w(3);
		rchk(`TMI_OFS_FLAG + 8'h04, 8'h00);
		@(posedge clk) tempA <= 8'd131;
		w(3);
		rchk(`TMI_OFS_FLAG + 8'h04, 8'h04);
		host.wr(`TMI_OFS_CFG, 8'h01);
		@(posedge clk) tempA <= 8'd140;
		w(3);
		host.service(0);
		rchk(`TMI_OFS_FLAG + 8'h04, 8'h00);
		@(posedge clk) tempA <= 8'd141;
		w(3);
		rchk(`TMI_OFS_FLAG + 8'h04, 8'h04);
		// Orderly, then escalation before the turn-off ends
		@(posedge clk) tempA <= 8'd150;
		w(2);
		chk({6'h0, ordOff, immOff}, 8'h02);
		rchk(`TMI_OFS_TSTAT, 8'h3d);
		rchk(`TMI_OFS_FLAG + 8'h03, 8'h20);
		@(posedge clk) tempA <= 8'd160;
		w(2);
		chk({6'h0, immOff, pullDn}, 8'h03);
		rchk(`TMI_OFS_FLAG + 8'h02, 8'h01);
		@(posedge clk) begin
			offDone <= 1'b1;
			restart <= 1'b1;
			tempA <= 8'd145;
		end
		w(4);
		chk({6'h0, safeRec, rstBlk}, 8'h03);
		@(posedge clk) tempA <= 8'd100;
		w(4);
		chk({6'h0, safeRec, rstBlk}, 8'h00);
		$display("test shutdown done");
		// Low-power polling and supervision gating
		host.wr(`TMI_OFS_CFG, 8'h03);
		w(3);
		chk({6'h0, sensEn}, 8'h01);
		@(posedge clk) tempA <= 8'd141;
		w(3);
		chk({6'h0, sensEn}, 8'h03);
		@(posedge clk) standby <= 1'b1;
		w(3);
		chk({6'h0, sensEn}, 8'h00);
		@(posedge clk) begin
			standby <= 1'b0;
			railOn <= 1'b0;
		end
		w(3);
		chk({6'h0, sensEn}, 8'h00);
		$display("test monitor done");
		// Enable low: no event recorded, no mask written
		@(posedge clk) ce <= 1'b0;
		pulse(0);
		host.wr(`TMI_OFS_MASK, 8'hff);
		@(posedge clk) ce <= 1'b1;
		rchk(`TMI_OFS_FLAG, 8'h00);
		rchk(`TMI_OFS_MASK, 8'h00);
		chk({7'h0, intOut_n}, 8'h00);
		$display("test enable done");
		// Reset in mid-run with flags and records still set
		@(posedge clk) nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rchk(`TMI_OFS_TSTAT, 8'h00);
		rchk(`TMI_OFS_CFG, `TMI_CFG_RST);
		rchk(`TMI_OFS_TOP, 8'h00);
		chk({7'h0, intOut_n}, 8'h01);
		chk(spiStatus, 8'h80);
		$display("test midrun reset done");
		print_verdict();
	end
endmodule : tmi_thermal_irq_tb
